//--- design/port_direction_pullup_control.v
// Port direction, latch, pull-up and alternate-function control for ports 0, 4, 6, 12, 13
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "port_ctl_regs.vh"
module port_direction_pullup_control (
	input wire clock, // System clock, 250 MHz
	input wire rstn, // Asynchronous reset, active low
	input wire [7:0] addr, // Register address
	input wire [7:0] wdata, // Write data; bit writes use bit 0
	input wire wr, // Byte write strobe
	input wire bit_wr, // Single-bit write strobe
	input wire [2:0] bit_sel, // Bit position for bit writes
	input wire rd, // Read strobe
	output reg [7:0] rdata, // Read data, valid the cycle after rd
	output reg irq, // Level interrupt, unmasked status set
	input wire [7:0] port0_in, // Port zero pin levels
	output reg [7:0] port0_out, // Port zero drive levels
	output reg [7:0] port0_oe, // Port zero output enables
	output reg [7:0] port0_pu, // Port zero pull-up enables
	input wire [7:0] port4_in, // Port four pin levels
	output reg [7:0] port4_out, // Port four drive levels
	output reg [7:0] port4_oe, // Port four output enables
	output reg [7:0] port4_pu, // Port four pull-up enables
	input wire [3:0] port6_in, // Port six bits 7..4 pin levels
	output reg [3:0] port6_out, // Port six bits 7..4 drive levels
	output reg [3:0] port6_oe, // Port six bits 7..4 output enables
	output reg [3:0] port6_pu, // Port six bits 7..4 pull-up enables
	input wire [7:0] port12_in, // Port twelve pin levels
	output reg [7:0] port12_out, // Port twelve drive levels
	output reg [7:0] port12_oe, // Port twelve output enables
	output reg [7:0] port12_pu, // Port twelve pull-up enables
	input wire [1:0] port13_in, // Port thirteen pin levels
	output reg [1:0] port13_out, // Port thirteen drive levels
	output reg [1:0] port13_oe, // Port thirteen output enables
	output reg [1:0] port13_pu, // Port thirteen pull-up enables
	input wire [7:0] realtime_out_en, // Real-time output function active per pin
	input wire [7:0] realtime_out_pins, // Real-time output data
	input wire [1:0] converter_out_en, // Converter output channel active
	input wire subclock_crystal_in, // Subclock crystal uses port0_bit7
	input wire [7:0] ebus_ad_out, // External bus address/data out
	input wire ebus_ad_oe, // External bus drives address/data
	input wire ebus_rd_n, // External bus read strobe, active low
	input wire ebus_wr_n, // External bus write strobe, active low
	input wire ebus_astb, // External bus address strobe
	output reg ebus_wait_n, // External wait from port6_bit6, active low
	output reg [7:0] ebus_ad_in, // External bus data read back
	output reg [7:0] ext_irq_req // Port zero interrupt request pulses
);
	reg [7:0] lat0_r, lat4_r, lat12_r;
	reg [3:0] lat6_r;
	reg [1:0] lat13_r;
	reg [7:0] dir0_r, dir12_r;
	reg [3:0] dir6_r;
	reg [1:0] dir13_r;
	reg [7:0] pu_lower_r, pu_upper_r;
	reg [7:0] mem_expansion_cfg;
	reg [7:0] irq_stat_r, irq_en_r;
	reg [7:0] p0_prev_r;
	wire [7:0] p0_s, p4_s, p12_s;
	wire [3:0] p6_s;
	wire [1:0] p13_s;
	wire [2:0] mex_mode;
	wire [1:0] mex_wait;
	wire mex_on;
	wire wait_ext;
	reg [7:0] oe0_nxt, oe4_nxt, oe12_nxt;
	reg [3:0] oe6_nxt, out6_nxt;
	reg [1:0] oe13_nxt;
	reg [7:0] out4_nxt, out12_nxt;
	reg [7:0] rdata_nxt;
	reg [7:0] p0_chg;
	reg [7:0] irq_set;
	reg [7:0] lat6_nxt, dir6_nxt, lat13_nxt, dir13_nxt;

	// Pins come from outside the clock domain
	sync_stage #(.W(8)) u_s0 (.clock(clock), .rstn(rstn), .d(port0_in), .q(p0_s));
	sync_stage #(.W(8)) u_s4 (.clock(clock), .rstn(rstn), .d(port4_in), .q(p4_s));
	sync_stage #(.W(4)) u_s6 (.clock(clock), .rstn(rstn), .d(port6_in), .q(p6_s));
	sync_stage #(.W(8)) u_s12 (.clock(clock), .rstn(rstn), .d(port12_in), .q(p12_s));
	sync_stage #(.W(2)) u_s13 (.clock(clock), .rstn(rstn), .d(port13_in), .q(p13_s));

	assign mex_mode = mem_expansion_cfg[`MEX_MODE_MSB:`MEX_MODE_LSB];
	assign mex_wait = mem_expansion_cfg[`MEX_WAIT_MSB:`MEX_WAIT_LSB];
	assign mex_on = mex_mode[2];
	assign wait_ext = mex_on && (mex_wait == `MEX_WAIT_EXT);

	// Byte write or single-bit write merged into the old value
	function [7:0] upd;
		input [7:0] old;
		input byte_we;
		input bit_we;
		input [2:0] sel;
		input [7:0] d;
		begin
			upd = old;
			if (byte_we)
				upd = d;
			else if (bit_we)
				upd[sel] = d[0];
		end
	endfunction

	// Narrow registers reuse the byte-wide merge; only their own bits are kept
	always @*
	begin
		lat6_nxt = upd({lat6_r, 4'h0}, wr && addr == `OFS_PORT6,
			bit_wr && addr == `OFS_PORT6, bit_sel, wdata);
		dir6_nxt = upd({dir6_r, 4'h0}, wr && addr == `OFS_DIR6,
			bit_wr && addr == `OFS_DIR6, bit_sel, wdata);
		lat13_nxt = upd({6'h00, lat13_r}, wr && addr == `OFS_PORT13,
			bit_wr && addr == `OFS_PORT13, bit_sel, wdata);
		dir13_nxt = upd({6'h00, dir13_r}, wr && addr == `OFS_DIR13,
			bit_wr && addr == `OFS_DIR13, bit_sel, wdata);
	end

	// Register writes; bit writes allowed everywhere except dir_reg_twelve and the interrupt status
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			lat0_r <= `RST_LATCH;
			lat4_r <= `RST_LATCH;
			lat6_r <= 4'h0;
			lat12_r <= `RST_LATCH;
			lat13_r <= 2'h0;
			dir0_r <= `RST_DIR;
			dir6_r <= 4'hF;
			dir12_r <= `RST_DIR;
			dir13_r <= 2'h3;
			pu_lower_r <= `RST_PU;
			pu_upper_r <= `RST_PU;
			mem_expansion_cfg <= `RST_MEM_EXP;
			irq_en_r <= 8'h00;
		end
		else
		begin
			// Writes always land in the latch, whatever the direction
			lat0_r <= upd(lat0_r, wr && addr == `OFS_PORT0, bit_wr && addr == `OFS_PORT0,
				bit_sel, wdata);
			lat4_r <= upd(lat4_r, wr && addr == `OFS_PORT4, bit_wr && addr == `OFS_PORT4,
				bit_sel, wdata);
			lat6_r <= lat6_nxt[7:4];
			lat12_r <= upd(lat12_r, wr && addr == `OFS_PORT12, bit_wr && addr == `OFS_PORT12,
				bit_sel, wdata);
			lat13_r <= lat13_nxt[1:0];
			dir0_r <= upd(dir0_r, wr && addr == `OFS_DIR0, bit_wr && addr == `OFS_DIR0,
				bit_sel, wdata) | `P0_FIXED_IN;
			dir6_r <= dir6_nxt[7:4];
			dir12_r <= upd(dir12_r, wr && addr == `OFS_DIR12, 1'b0, bit_sel, wdata);
			dir13_r <= dir13_nxt[1:0];
			pu_lower_r <= upd(pu_lower_r, wr && addr == `OFS_PU_LOWER,
				bit_wr && addr == `OFS_PU_LOWER, bit_sel, wdata);
			pu_upper_r <= upd(pu_upper_r, wr && addr == `OFS_PU_UPPER,
				bit_wr && addr == `OFS_PU_UPPER, bit_sel, wdata);
			mem_expansion_cfg <= upd(mem_expansion_cfg, wr && addr == `OFS_MEM_EXP,
				bit_wr && addr == `OFS_MEM_EXP, bit_sel, wdata);
			irq_en_r <= upd(irq_en_r, wr && addr == `OFS_IRQ_EN,
				bit_wr && addr == `OFS_IRQ_EN, bit_sel, wdata);
		end
	end

	// Pin drive; memory-expansion settings take over port four and override the port six direction register for bits 7, 5 and 4
	always @*
	begin
		oe0_nxt = ~dir0_r & ~`P0_FIXED_IN;
		oe12_nxt = ~dir12_r;
		out12_nxt = (lat12_r & ~realtime_out_en) | (realtime_out_pins & realtime_out_en);
		oe13_nxt = ~dir13_r;
		out4_nxt = lat4_r;
		oe4_nxt = {8{mex_mode[0]}};
		out6_nxt = lat6_r;
		oe6_nxt = ~dir6_r;
		if (mex_on)
		begin
			out4_nxt = ebus_ad_out;
			oe4_nxt = {8{ebus_ad_oe}};
			out6_nxt = {ebus_astb, lat6_r[2], ebus_wr_n, ebus_rd_n};
			// Bit six is a plain pin unless external wait is chosen
			oe6_nxt = {1'b1, wait_ext ? 1'b0 : ~dir6_r[2], 2'h3};
		end
	end

	// Read mux: pin level for inputs, latch for outputs; active converter pins and port zero bit seven under crystal use read zero
	always @*
	begin
		rdata_nxt = 8'h00;
		case (addr)
			`OFS_PORT0:
			begin
				rdata_nxt = (p0_s & dir0_r) | (lat0_r & ~dir0_r);
				if (subclock_crystal_in)
					rdata_nxt[7] = 1'b0;
			end
			`OFS_PORT4: rdata_nxt = (p4_s & ~oe4_nxt) | (lat4_r & oe4_nxt);
			`OFS_PORT6: rdata_nxt = {(p6_s & ~oe6_nxt) | (lat6_r & oe6_nxt), 4'h0};
			`OFS_PORT12: rdata_nxt = (p12_s & dir12_r) | (lat12_r & ~dir12_r);
			`OFS_PORT13: rdata_nxt = {6'h00, ((p13_s & dir13_r) | (lat13_r & ~dir13_r))
				& ~converter_out_en};
			`OFS_DIR0: rdata_nxt = dir0_r;
			`OFS_DIR6: rdata_nxt = {dir6_r, 4'hF};
			`OFS_DIR12: rdata_nxt = dir12_r;
			`OFS_DIR13: rdata_nxt = {6'h3F, dir13_r};
			`OFS_PU_LOWER: rdata_nxt = pu_lower_r;
			`OFS_PU_UPPER: rdata_nxt = pu_upper_r;
			`OFS_MEM_EXP: rdata_nxt = mem_expansion_cfg;
			`OFS_IRQ_STAT: rdata_nxt = irq_stat_r;
			`OFS_IRQ_EN: rdata_nxt = irq_en_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	// Port zero events: a pin edge on bits 0 to 6, or a write that changes a driven level
	always @*
	begin
		p0_chg = (p0_s ^ p0_prev_r) & 8'h7F;
		irq_set = p0_chg;
		if (wr && addr == `OFS_PORT0)
			irq_set = irq_set | ((wdata ^ lat0_r) & ~dir0_r);
		if (bit_wr && addr == `OFS_PORT0 && !dir0_r[bit_sel] && (wdata[0] != lat0_r[bit_sel]))
			irq_set[bit_sel] = 1'b1;
	end

	// Sticky status, write one to clear; a new event wins over the clear
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			irq_stat_r <= 8'h00;
			p0_prev_r <= 8'h00;
			ext_irq_req <= 8'h00;
			irq <= 1'b0;
		end
		else
		begin
			p0_prev_r <= p0_s;
			ext_irq_req <= irq_set;
			if (wr && addr == `OFS_IRQ_STAT)
				irq_stat_r <= (irq_stat_r & ~wdata) | irq_set;
			else
				irq_stat_r <= irq_stat_r | irq_set;
			irq <= |(irq_stat_r & irq_en_r);
		end
	end

	// Registered pin, pull-up and read outputs
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata <= 8'h00;
			port0_out <= 8'h00;
			port0_oe <= 8'h00;
			port0_pu <= 8'h00;
			port4_out <= 8'h00;
			port4_oe <= 8'h00;
			port4_pu <= 8'h00;
			port6_out <= 4'h0;
			port6_oe <= 4'h0;
			port6_pu <= 4'h0;
			port12_out <= 8'h00;
			port12_oe <= 8'h00;
			port12_pu <= 8'h00;
			port13_out <= 2'h0;
			port13_oe <= 2'h0;
			port13_pu <= 2'h0;
			ebus_wait_n <= 1'b1;
			ebus_ad_in <= 8'h00;
		end
		else
		begin
			// Data stand only in the cycle after the read strobe
			rdata <= rd ? rdata_nxt : 8'h00;
			port0_out <= lat0_r;
			port0_oe <= oe0_nxt;
			// Bits zero and seven have no pull-up at all
			port0_pu <= {8{pu_lower_r[`PU_LO_P0]}} & ~oe0_nxt & ~`P0_FIXED_IN;
			port4_out <= out4_nxt;
			port4_oe <= oe4_nxt;
			port4_pu <= {8{pu_lower_r[`PU_LO_P4] & ~mex_on}} & ~oe4_nxt;
			port6_out <= out6_nxt;
			port6_oe <= oe6_nxt;
			port6_pu <= {4{pu_lower_r[`PU_LO_P6] & ~mex_on}} & ~oe6_nxt;
			port12_out <= out12_nxt;
			port12_oe <= oe12_nxt;
			port12_pu <= {8{pu_upper_r[`PU_UP_P12]}} & dir12_r;
			port13_out <= lat13_r;
			port13_oe <= oe13_nxt & ~converter_out_en;
			// Converter pins are analog, never pulled up
			port13_pu <= {2{pu_upper_r[`PU_UP_P13]}} & dir13_r & ~converter_out_en;
			ebus_wait_n <= wait_ext ? p6_s[2] : 1'b1;
			ebus_ad_in <= p4_s;
		end
	end
endmodule

//--- design/port_ctl_regs.vh
// Register offsets, field positions and reset values of the port control block
`ifndef PORT_CTL_REGS_VH
`define PORT_CTL_REGS_VH

// Port data registers
`define OFS_PORT0 8'h00
`define OFS_PORT4 8'h04
`define OFS_PORT6 8'h06
`define OFS_PORT12 8'h0C
`define OFS_PORT13 8'h0D
// Direction registers, one means input
`define OFS_DIR0 8'h20
`define OFS_DIR6 8'h26
`define OFS_DIR12 8'h2C
`define OFS_DIR13 8'h2D
// Pull-up options
`define OFS_PU_LOWER 8'h30
`define OFS_PU_UPPER 8'h31
// Memory-expansion configuration
`define OFS_MEM_EXP 8'hF8
// Interrupt status (write one to clear) and enable
`define OFS_IRQ_STAT 8'hE0
`define OFS_IRQ_EN 8'hE1

// Reset values
`define RST_DIR 8'hFF
`define RST_PU 8'h00
`define RST_MEM_EXP 8'h10
`define RST_LATCH 8'h00

// Pull-up group bits
`define PU_LO_P0 0
`define PU_LO_P4 4
`define PU_LO_P6 6
`define PU_UP_P12 4
`define PU_UP_P13 5

// Memory-expansion fields
`define MEX_MODE_LSB 0
`define MEX_MODE_MSB 2
`define MEX_WAIT_LSB 4
`define MEX_WAIT_MSB 5
`define MEX_WAIT_EXT 2'h3

// Port zero bits that are input only
`define P0_FIXED_IN 8'h81

`endif

//--- design/sync_stage.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sync_stage #(
	parameter W = 8
) (
	input wire clock, // System clock
	input wire rstn, // Asynchronous reset, active low
	input wire [W-1:0] d, // Asynchronous input
	output reg [W-1:0] q // Synchronised output
);
	reg [W-1:0] meta_r;

	// First stage is read only by the second
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_r <= {W{1'b0}};
			q <= {W{1'b0}};
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

//--- tb/port_ctl_sva.sv
// Port-level assertions for the port control block
`timescale 1ns/1ns
module port_ctl_sva (
	input wire clock, // Clock
	input wire rstn, // Reset
	input wire [7:0] addr, // Address
	input wire [7:0] wdata, // Write data
	input wire wr, // Byte write
	input wire bit_wr, // Bit write
	input wire irq, // Interrupt
	input wire [7:0] port0_out, // P0 drive
	input wire [7:0] port0_oe, // P0 enable
	input wire [7:0] port0_pu, // P0 pull-up
	input wire [7:0] port12_oe, // P12 enable
	input wire [7:0] port12_pu, // P12 pull-up
	input wire [1:0] port13_oe, // P13 enable
	input wire [1:0] port13_pu, // P13 pull-up
	input wire [1:0] converter_out_en, // Converter on
	input wire [7:0] ext_irq_req // P0 events
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// Steps that start a check: the register write that should show later at the pins
	sequence dir12_wr; wr && addr == 8'h2C; endsequence
	sequence dir13_wr; wr && addr == 8'h2D; endsequence
	sequence p0_level_chg; wr && addr == 8'h00 && |(port0_oe & (wdata ^ port0_out)); endsequence
	dir12_drive_a: assert property (dir12_wr |-> ##2 port12_oe == ~$past(wdata, 2))
		else $error("port12 enables miss direction write");
	dir13_drive_a: assert property (dir13_wr |-> ##2
		port13_oe == (~$past(wdata[1:0], 2) & ~$past(converter_out_en)))
		else $error("port13 enables miss direction write");
	dir12_bit_a: assert property (bit_wr && addr == 8'h2C |-> ##2 $stable(port12_oe))
		else $error("bit write changed port12 direction");
	reset_state_a: assert property ($rose(rstn) |-> port0_oe == 8'h00 && port12_oe == 8'h00
		&& port13_oe == 2'h0 && port12_pu == 8'h00 && port13_pu == 2'h0)
		else $error("pins not idle after reset");
	p0_fixed_in_a: assert property (port0_oe[0] == 1'b0 && port0_oe[7] == 1'b0)
		else $error("input-only port0 pin driven");
	pu_not_out_a: assert property ((port0_pu & port0_oe) == 8'h00
		&& (port12_pu & port12_oe) == 8'h00 && (port13_pu & port13_oe) == 2'h0)
		else $error("pull-up on a driven pin");
	pu12_group_a: assert property (port12_pu == 8'h00 || (port12_pu | port12_oe) == 8'hFF)
		else $error("port12 pull-ups not grouped");
	p0_event_a: assert property (p0_level_chg |-> ##[1:4] ext_irq_req != 8'h00)
		else $error("port0 level change raised no event");
	irq_mask_a: assert property (wr && addr == 8'hE1 && wdata == 8'h00 |-> ##2 !irq)
		else $error("masked interrupt still high");
endmodule
bind port_direction_pullup_control port_ctl_sva u_sva (.*);

//--- tb/pin_world.sv
// Pin-side model: resolves each pin from own drive, outside drive and pull-up
`timescale 1ns/1ns
module pin_world (
	input wire clock, // Clock
	input wire [29:0] ext_en, // Outside drive present
	input wire [29:0] ext_val, // Outside drive level
	input wire [29:0] pin_out, // Block drive levels
	input wire [29:0] pin_oe, // Block drive enables
	input wire [29:0] pin_pu, // Block pull-ups
	output wire [29:0] pin_in // Resolved pin levels
);
	reg [29:0] noise_r = 30'h15555555;
	// A floating line wanders, so a stale level never passes for a real one
	always @(posedge clock)
	begin
		noise_r <= ~noise_r;
	end
	// Own driver wins, then the outside tie, then pull-up or float
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pin_pu | noise_r));
endmodule

//--- tb/port_direction_pullup_control_tb.sv
// Register-level tests of the port control block against a pin model
`timescale 1ns/1ns
module port_direction_pullup_control_tb;
	logic clock = 1'b0, rstn = 1'b0, wr = 1'b0, bit_wr = 1'b0, rd = 1'b0;
	logic ebus_ad_oe = 1'b0, subclock_crystal_in = 1'b0;
	logic ebus_rd_n = 1'b1, ebus_wr_n = 1'b1, ebus_astb = 1'b1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, ebus_ad_out = 8'h00;
	logic [7:0] realtime_out_en = 8'h00, realtime_out_pins = 8'h00;
	logic [2:0] bit_sel = 3'h0;
	logic [1:0] converter_out_en = 2'h0;
	logic [29:0] ext_en = 30'h3FFFFFFE, ext_val = 30'h00000000;
	logic [7:0] rst_a [6] = '{8'h20, 8'h2C, 8'h2D, 8'h30, 8'h31, 8'hF8};
	logic [7:0] rst_v [6] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h10};
	wire irq, ebus_wait_n;
	wire [29:0] pin_in;
	wire [7:0] rdata, ebus_ad_in, ext_irq_req, port0_in, port4_in, port12_in;
	wire [7:0] port0_out, port0_oe, port0_pu, port4_out, port4_oe, port4_pu;
	wire [7:0] port12_out, port12_oe, port12_pu;
	wire [3:0] port6_in, port6_out, port6_oe, port6_pu;
	wire [1:0] port13_in, port13_out, port13_oe, port13_pu;
	int i, cmp_count = 0, miscompares = 0;

	port_direction_pullup_control u_dut (.*);
	pin_world u_pins (
		.clock(clock),
		.ext_en(ext_en),
		.ext_val(ext_val),
		.pin_out({port0_out, port4_out, port6_out, port12_out, port13_out}),
		.pin_oe({port0_oe, port4_oe, port6_oe, port12_oe, port13_oe}),
		.pin_pu({port0_pu, port4_pu, port6_pu, port12_pu, port13_pu}),
		.pin_in(pin_in)
	);
	assign {port0_in, port4_in, port6_in, port12_in, port13_in} = pin_in;

	// Free-running system clock
	initial
		forever
			#2 clock = ~clock;

	task check(input [7:0] seen, input [7:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	end
	endtask

	// One bus cycle: kind 0 byte write, 1 bit write at position e, 2 read expecting e
	task acc(input [1:0] k, input [7:0] a, input [7:0] d, input [7:0] e);
	begin
		@(posedge clock);
		addr <= a;
		wdata <= d;
		bit_sel <= e[2:0];
		wr <= (k == 2'h0);
		bit_wr <= (k == 2'h1);
		rd <= (k == 2'h2);
		@(posedge clock);
		wr <= 1'b0;
		bit_wr <= 1'b0;
		rd <= 1'b0;
		if (k == 2'h2)
		begin
			#1;
			check(rdata, e);
		end
	end
	endtask

	// Long enough for register, pin sync and interrupt stages to land
	task settle;
	begin
		repeat (4) @(posedge clock);
		#1;
	end
	endtask

	task wrap_up;
	begin
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask

	// Watchdog, far beyond the roughly 140 cycles the tests need
	initial
	begin
		#20000;
		miscompares = miscompares + 1;
		wrap_up;
	end

	initial
	begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		for (i = 0; i < 6; i = i + 1)
			acc(2'h2, rst_a[i], 8'h00, rst_v[i]);
		// Direction: byte write lands, bit write to port twelve is refused
		acc(2'h0, 8'h2C, 8'hFE, 8'h00);
		acc(2'h1, 8'h2C, 8'h00, 8'h01);
		acc(2'h2, 8'h2C, 8'h00, 8'hFE);
		acc(2'h1, 8'h2D, 8'h00, 8'h00);
		acc(2'h2, 8'h2D, 8'h00, 8'hFE);
		acc(2'h0, 8'h31, 8'h30, 8'h00);
		settle;
		check(port12_oe, 8'h01);
		check({6'h00, port13_oe}, 8'h01);
		check(port12_pu, 8'hFE);
		check({6'h00, port13_pu}, 8'h02);
		// Mixed directions: read gives pins for inputs, latch for outputs
		@(posedge clock);
		ext_val[9:2] <= 8'hA5;
		acc(2'h0, 8'h2C, 8'h0F, 8'h00);
		acc(2'h0, 8'h0C, 8'h3C, 8'h00);
		settle;
		acc(2'h2, 8'h0C, 8'h00, 8'h35);
		check(port12_out & 8'hF0, 8'h30);
		// Real-time outputs replace the latch once the pins are outputs
		acc(2'h0, 8'h2C, 8'h00, 8'h00);
		realtime_out_en <= 8'hFF;
		realtime_out_pins <= 8'h5A;
		settle;
		check(port12_out, 8'h5A);
		check(port12_pu, 8'h00);
		@(posedge clock);
		realtime_out_en <= 8'h00;
		// Lower pull-ups: none on the input-only port zero pins
		acc(2'h0, 8'h30, 8'h51, 8'h00);
		settle;
		check(port0_pu, 8'h7E);
		check(port4_pu, 8'hFF);
		check({4'h0, port6_pu}, 8'h0F);
		// Port zero: fixed inputs, level change raises, mask and clear the interrupt
		acc(2'h0, 8'h20, 8'h00, 8'h00);
		acc(2'h2, 8'h20, 8'h00, 8'h81);
		acc(2'h0, 8'hE0, 8'hFF, 8'h00);
		acc(2'h0, 8'hE1, 8'h02, 8'h00);
		acc(2'h0, 8'h00, 8'h02, 8'h00);
		settle;
		check(port0_oe, 8'h7E);
		check(port0_pu, 8'h00);
		check(port0_out, 8'h02);
		check({7'h00, irq}, 8'h01);
		acc(2'h2, 8'hE0, 8'h00, 8'h02);
		acc(2'h0, 8'hE1, 8'h00, 8'h00);
		settle;
		check({7'h00, irq}, 8'h00);
		acc(2'h0, 8'hE1, 8'h02, 8'h00);
		settle;
		check({7'h00, irq}, 8'h01);
		acc(2'h0, 8'hE0, 8'h02, 8'h00);
		settle;
		check({7'h00, irq}, 8'h00);
		// Crystal use hides the bit seven pin level
		@(posedge clock);
		ext_val[29] <= 1'b1;
		settle;
		acc(2'h2, 8'h00, 8'h00, 8'h82);
		subclock_crystal_in <= 1'b1;
		acc(2'h2, 8'h00, 8'h00, 8'h02);
		subclock_crystal_in <= 1'b0;
		// External bus mode, first without and then with the wait pin
		ebus_ad_oe <= 1'b1;
		ebus_ad_out <= 8'hC3;
		acc(2'h0, 8'hF8, 8'h04, 8'h00);
		settle;
		check(port4_out, 8'hC3);
		check(port4_oe, 8'hFF);
		check({4'h0, port6_oe}, 8'h0B);
		check({7'h00, ebus_wait_n}, 8'h01);
		check({4'h0, port6_out}, 8'h0B);
		check(port4_pu, 8'h00);
		check({4'h0, port6_pu}, 8'h00);
		acc(2'h1, 8'h26, 8'h00, 8'h06);
		settle;
		check({4'h0, port6_oe}, 8'h0F);
		check(ebus_ad_in, 8'hC3);
		acc(2'h0, 8'hF8, 8'h34, 8'h00);
		settle;
		check({4'h0, port6_oe}, 8'h0B);
		check({7'h00, ebus_wait_n}, 8'h00);
		// One converter channel, the other parked as a low output
		acc(2'h0, 8'h0D, 8'h00, 8'h00);
		acc(2'h0, 8'h2D, 8'hFD, 8'h00);
		converter_out_en <= 2'h1;
		settle;
		check({6'h00, port13_oe}, 8'h02);
		check({6'h00, port13_out}, 8'h00);
		acc(2'h2, 8'h0D, 8'h00, 8'h00);
		acc(2'h2, 8'h7F, 8'h00, 8'h00);
		wrap_up;
	end
endmodule
